// file: verilog/acs_device.sv
// Device end: receives 16-bit write frames, holds the control word, channel
// list and range registers, and picks the channel and range of each conversion.
// Assumes the link pins come from another clock domain and the serial clock
// runs well below a quarter of clk.
//
// Behaviour
// - Sequencer bits 00: convert addressed channel
// - Sequencer bits 11: same as manual mode
// - Bits 01: start at lowest listed channel
// - List mode: ascending order, wrap, repeat
// - Bits 10: channels 0 to final, repeat
// - Sequences use each channel's stored range
// - Eight-bit write-only channel list register
// - List bit one includes that channel
// - Frame: write, select, channels 0-7, zeros
// - Range low group: channels 0-3, A then B
// - Host writes range low with select 01
// - Stored range applied whenever channel converts
// - Range high group: channels 4-7, same layout
// - Power-up range is plus minus 10 V
// - Codes 00 10V, 01 5V, 10 2.5V, 11 unipolar
// - Store sixteen-bit frame only when write set
// - Sequence runs on while list and bits unchanged; code restarts on any control or list write, same values or not
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
module acs_device
    import acs_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    acs_link_if.dev link,
    output logic convStart,
    output logic [2:0] convChannel,
    output logic [1:0] convRange,
    output logic [1:0] seqMode,
    output logic [12:0] controlWord
);

    typedef enum logic [1:0] {
        ACS_D_IDLE = 2'b01,
        ACS_D_SHIFT = 2'b10
    } acs_dstate_t;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // First listed channel at or after start, wrapping; fallback when empty
    function automatic logic [2:0] acsFirstFrom(input logic [7:0] list, input logic [2:0] start,
                                                input logic [2:0] fallback);
        logic [2:0] idx;
        logic found;
        found = 1'b0;
        acsFirstFrom = fallback;
        for (int i = 0; i < 8; i++) begin
            idx = start + 3'(i);
            if (!found && list[idx]) begin
                found = 1'b1;
                acsFirstFrom = idx;
            end
        end
    endfunction

    // Range field of one channel from an 8-bit group, channel 0 in the top pair
    function automatic logic [1:0] acsRangeField(input logic [7:0] group, input logic [1:0] slot);
        logic [2:0] pos;
        pos = 3'h6 - {slot, 1'b0};
        acsRangeField = group[pos +: 2];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage is read by logic
    logic [1:0] sclkSync;
    logic [1:0] csSync;
    logic [1:0] dinSync;
    logic sclkPrev;
    logic csPrev;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sclkSync <= 2'b11;
            csSync <= 2'b11;
            dinSync <= 2'b00;
            sclkPrev <= 1'b1;
            csPrev <= 1'b1;
        end else if (ce) begin
            sclkSync <= {sclkSync[0], link.sclk};
            csSync <= {csSync[0], link.csN};
            dinSync <= {dinSync[0], link.din};
            sclkPrev <= sclkSync[1];
            csPrev <= csSync[1];
        end
    end

    logic sclkRise;
    logic csFall;
    assign sclkRise = sclkSync[1] && !sclkPrev;
    assign csFall = !csSync[1] && csPrev;

    ////////////////////////////////////////////////////////////////////////////
    // Frame receiver
    acs_dstate_t state;
    logic [14:0] shiftReg;
    logic [3:0] bitCnt;
    logic frameDone;
    logic [15:0] frame;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= ACS_D_IDLE;
            shiftReg <= 15'h0000;
            bitCnt <= 4'h0;
            frameDone <= 1'b0;
            frame <= 16'h0000;
        end else if (ce) begin
            frameDone <= 1'b0;
            case (state)
                ACS_D_IDLE: begin
                    bitCnt <= 4'h0;
                    if (csFall) begin
                        state <= ACS_D_SHIFT;
                    end
                end
                ACS_D_SHIFT: begin
                    // A frame cut short by chip select is dropped whole
                    if (csSync[1]) begin
                        state <= ACS_D_IDLE;
                    end else if (sclkRise) begin
                        shiftReg <= {shiftReg[13:0], dinSync[1]};
                        bitCnt <= bitCnt + 4'h1;
                        if (bitCnt == 4'(FRAME_BITS - 1)) begin
                            frame <= {shiftReg, dinSync[1]};
                            frameDone <= 1'b1;
                            state <= ACS_D_IDLE;
                        end
                    end
                end
                default: state <= ACS_D_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register decode of a finished frame
    logic frameWrite;
    logic [1:0] frameSel;
    logic [7:0] frameData;
    logic [7:0] chanList;
    logic [7:0] rangeLow;
    logic [7:0] rangeHigh;
    logic [7:0] next_chanList;
    logic [7:0] next_rangeLow;
    logic [7:0] next_rangeHigh;
    logic [12:0] next_controlWord;
    logic restart;

    assign frameWrite = frameDone && frame[WRITE_BIT];
    assign frameSel = frame[SEL_MSB:SEL_LSB];
    assign frameData = frame[DATA_MSB:DATA_LSB];

    always_comb begin
        next_chanList = chanList;
        next_rangeLow = rangeLow;
        next_rangeHigh = rangeHigh;
        next_controlWord = controlWord;
        restart = 1'b0;
        if (frameWrite) begin
            case (frameSel)
                SEL_CONTROL: begin
                    next_controlWord = frame[CTRL_MSB:CTRL_LSB];
                    restart = 1'b1;
                end
                SEL_RANGE_LOW: next_rangeLow = frameData;
                SEL_RANGE_HIGH: next_rangeHigh = frameData;
                SEL_CHAN_LIST: begin
                    next_chanList = frameData;
                    restart = 1'b1;
                end
                default: next_controlWord = controlWord;
            endcase
        end
    end

    // Write-only storage: nothing here can be read back over the link
    always_ff @(posedge clk) begin
        if (!resetn) begin
            chanList <= CHAN_LIST_RESET;
            rangeLow <= {4{RANGE_RESET}};
            rangeHigh <= {4{RANGE_RESET}};
            controlWord <= CONTROL_RESET;
        end else if (ce) begin
            chanList <= next_chanList;
            rangeLow <= next_rangeLow;
            rangeHigh <= next_rangeHigh;
            controlWord <= next_controlWord;
        end
    end

    assign seqMode = {controlWord[SEQ_HI_BIT], controlWord[SEQ_LO_BIT]};

    ////////////////////////////////////////////////////////////////////////////
    // Channel sequencing; one step per finished frame, whatever its write flag
    logic [1:0] next_mode;
    logic [2:0] next_addr;
    logic [7:0] listOrder;
    logic [2:0] next_channel;
    logic [1:0] next_range;

    assign next_mode = {next_controlWord[SEQ_HI_BIT], next_controlWord[SEQ_LO_BIT]};
    assign next_addr = next_controlWord[ADDR_MSB:ADDR_LSB];

    // Channel 0 sits in the top data bit, so reverse into index order
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            listOrder[i] = next_chanList[CHANNELS - 1 - i];
        end
    end

    always_comb begin
        case (next_mode)
            SEQ_LIST: begin
                if (restart) begin
                    next_channel = acsFirstFrom(listOrder, 3'h0, 3'h0);
                end else begin
                    next_channel = acsFirstFrom(listOrder, convChannel + 3'h1, convChannel);
                end
            end
            SEQ_CONSEC: begin
                if (restart || convChannel >= next_addr) begin
                    next_channel = 3'h0;
                end else begin
                    next_channel = convChannel + 3'h1;
                end
            end
            SEQ_MANUAL: next_channel = next_addr;
            SEQ_MANUAL_ALT: next_channel = next_addr;
            default: next_channel = next_addr;
        endcase
        // Latest stored code follows the channel in every mode
        if (next_channel[2]) begin
            next_range = acsRangeField(next_rangeHigh, next_channel[1:0]);
        end else begin
            next_range = acsRangeField(next_rangeLow, next_channel[1:0]);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            convChannel <= 3'h0;
            convRange <= RANGE_RESET;
        end else if (ce && frameDone) begin
            convChannel <= next_channel;
            convRange <= next_range;
        end
    end

    // Conversion begins at the start of the next frame with the chosen channel
    always_ff @(posedge clk) begin
        if (!resetn) begin
            convStart <= 1'b0;
        end else if (ce) begin
            convStart <= csFall && state == ACS_D_IDLE;
        end
    end

endmodule

// file: verilog/acs_pkg.sv
// Shared constants for the channel sequencer link: frame layout, register
// selects, range codes and the host's AHB-Lite register map.
// Assumes both ends and the bench import it whole.
package acs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame layout, bit 15 is sent first
    localparam int FRAME_BITS = 16;
    localparam int WRITE_BIT = 15;
    localparam int SEL_MSB = 14;
    localparam int SEL_LSB = 13;
    localparam int DATA_MSB = 12;
    localparam int DATA_LSB = 5;
    localparam int ADDR_MSB = 12;
    localparam int ADDR_LSB = 10;
    localparam int SEQ_HI_BIT = 3;
    localparam int SEQ_LO_BIT = 2;
    localparam int CTRL_MSB = 12;
    localparam int CTRL_LSB = 0;
    localparam int NUM_CHANNELS = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Register select codes carried in bits 14:13
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_RANGE_LOW = 2'h1;
    localparam logic [1:0] SEL_RANGE_HIGH = 2'h2;
    localparam logic [1:0] SEL_CHAN_LIST = 2'h3;

    // Sequencer selection {sequencer_sel_hi, sequencer_sel_lo}
    localparam logic [1:0] SEQ_MANUAL = 2'h0;
    localparam logic [1:0] SEQ_LIST = 2'h1;
    localparam logic [1:0] SEQ_CONSEC = 2'h2;
    localparam logic [1:0] SEQ_MANUAL_ALT = 2'h3;

    // Range codes {range_code_upper, range_code_lower}
    localparam logic [1:0] RANGE_PM10V = 2'h0;
    localparam logic [1:0] RANGE_PM5V = 2'h1;
    localparam logic [1:0] RANGE_PM2V5 = 2'h2;
    localparam logic [1:0] RANGE_UNI10V = 2'h3;

    // Power-up contents
    localparam logic [1:0] RANGE_RESET = RANGE_PM10V;
    localparam logic [7:0] CHAN_LIST_RESET = 8'h00;
    localparam logic [12:0] CONTROL_RESET = 13'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Host register map on AHB-Lite
    localparam logic [7:0] HOST_REG_FRAME = 8'h00;
    localparam logic [7:0] HOST_REG_STATUS = 8'h04;
    localparam logic [7:0] HOST_REG_DIVIDER = 8'h08;
    localparam int STATUS_BUSY_BIT = 0;

    // Link timing: serial clock period against the system clock
    localparam int CLK_PERIOD_NS = 40;
    localparam int LINK_PERIOD_NS = 320;
    localparam logic [7:0] DIVIDER_RESET = 8'(LINK_PERIOD_NS / CLK_PERIOD_NS / 2);

endpackage

// file: verilog/acs_link_if.sv
// Serial link between the host controller and the sequencer device.
// Assumes the host drives every wire; the device only listens.
interface acs_link_if;
    logic sclk;
    logic csN;
    logic din;

    modport host (
        output sclk,
        output csN,
        output din
    );

    modport dev (
        input sclk,
        input csN,
        input din
    );
endinterface

// file: verilog/acs_host.sv
// Host end: AHB-Lite register slave that sends 16-bit write frames on the link.
// Assumes one AHB master, single word transfers, zero wait states while ce is high.
module acs_host
    import acs_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    acs_link_if.host link
);

    typedef enum logic [4:0] {
        ACS_H_IDLE = 5'b00001,
        ACS_H_LEAD = 5'b00010,
        ACS_H_LOW = 5'b00100,
        ACS_H_HIGH = 5'b01000,
        ACS_H_GAP = 5'b10000
    } acs_hstate_t;

    acs_hstate_t state;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [15:0] frameReg;
    logic [15:0] shiftReg;
    logic [7:0] divider;
    logic [7:0] divCnt;
    logic [3:0] bitCnt;
    logic startReq;
    logic halfDone;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave; ce low stalls the bus rather than losing a transfer
    assign hreadyout = ce;
    assign hresp = 1'b0;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else if (ce) begin
            wrPend <= hsel && htrans[1] && hready && hwrite;
            if (hsel && htrans[1] && hready) begin
                wrAddr <= haddr[7:0];
                case (haddr[7:0])
                    HOST_REG_FRAME: hrdata <= {16'h0000, frameReg};
                    HOST_REG_STATUS: hrdata <= {31'h0000_0000, state != ACS_H_IDLE};
                    HOST_REG_DIVIDER: hrdata <= {24'h00_0000, divider};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // A frame written while busy is dropped; software polls busy first
    assign startReq = wrPend && wrAddr == HOST_REG_FRAME && state == ACS_H_IDLE;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            frameReg <= 16'h0000;
            divider <= DIVIDER_RESET;
        end else if (ce && wrPend) begin
            if (startReq) begin
                frameReg <= hwdata[15:0];
            end
            if (wrAddr == HOST_REG_DIVIDER) begin
                divider <= (hwdata[7:0] < 8'h02) ? 8'h02 : hwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame shifter: data changes on the falling edge, device samples on rising
    assign halfDone = divCnt >= divider - 8'h01;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= ACS_H_IDLE;
            divCnt <= 8'h00;
            bitCnt <= 4'h0;
            shiftReg <= 16'h0000;
            link.sclk <= 1'b1;
            link.csN <= 1'b1;
            link.din <= 1'b0;
        end else if (ce) begin
            divCnt <= halfDone ? 8'h00 : divCnt + 8'h01;
            case (state)
                ACS_H_IDLE: begin
                    divCnt <= 8'h00;
                    if (startReq) begin
                        shiftReg <= {hwdata[14:0], 1'b0};
                        link.din <= hwdata[15];
                        link.csN <= 1'b0;
                        bitCnt <= 4'h0;
                        state <= ACS_H_LEAD;
                    end
                end
                ACS_H_LEAD, ACS_H_HIGH: begin
                    if (halfDone) begin
                        if (state == ACS_H_HIGH && bitCnt == 4'(FRAME_BITS - 1)) begin
                            link.csN <= 1'b1;
                            state <= ACS_H_GAP;
                        end else begin
                            if (state == ACS_H_HIGH) begin
                                link.din <= shiftReg[15];
                                shiftReg <= {shiftReg[14:0], 1'b0};
                                bitCnt <= bitCnt + 4'h1;
                            end
                            link.sclk <= 1'b0;
                            state <= ACS_H_LOW;
                        end
                    end
                end
                ACS_H_LOW: begin
                    if (halfDone) begin
                        link.sclk <= 1'b1;
                        state <= ACS_H_HIGH;
                    end
                end
                // Select stays high a half period so back-to-back frames keep a clean gap
                ACS_H_GAP: begin
                    if (halfDone) begin
                        state <= ACS_H_IDLE;
                    end
                end
                default: state <= ACS_H_IDLE;
            endcase
        end
    end

endmodule

// file: sim/acs_link_asserts.sv
// Checker for the serial link and the conversion start and channel outputs of the device end.
// Assumes the bench instantiates it beside the link interface, every port named.
module acs_link_asserts
    import acs_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic csN,
    input wire logic din,
    input wire logic convStart,
    input wire logic [2:0] convChannel,
    input wire logic [1:0] seqMode,
    input wire logic [12:0] controlWord
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // Rising serial clock edges seen in the current frame
    logic sclkQ;
    logic [4:0] riseCount;

    always_ff @(posedge clk) begin
        sclkQ <= sclk;
    end

    always_ff @(posedge clk) begin
        if (!resetn || csN) begin
            riseCount <= 5'h0;
        end else if (sclk && !sclkQ) begin
            riseCount <= riseCount + 5'h1;
        end
    end

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////////
    chk_idle_clock_high: assert property (
        csN |-> sclk) else $error("serial clock low outside a frame");
    chk_frame_bit_count: assert property (
        $rose(csN) |-> riseCount == 5'(FRAME_BITS)) else $error("frame ended without sixteen clocks");
    chk_frame_gap_hold: assert property (
        $rose(csN) |-> csN [*3]) else $error("select gap too short");
    chk_data_steady_high: assert property (
        !csN && !$past(csN) && sclk && $past(sclk) |-> $stable(din)) else $error("data moved while clock high");
    chk_start_follows: assert property (
        $fell(csN) |-> ##[1:8] convStart) else $error("no conversion start after select");
    chk_start_pulse_one: assert property (
        convStart |=> !convStart) else $error("conversion start longer than one cycle");
    chk_start_in_frame: assert property (
        convStart |-> !csN) else $error("conversion start outside a frame");
    chk_consec_step: assert property (
        seqMode == SEQ_CONSEC && $stable(controlWord) && $changed(convChannel)
        |-> convChannel == $past(convChannel) + 3'h1 || convChannel == 3'h0) else $error("consecutive step skipped");
    chk_manual_channel: assert property (
        convStart && (seqMode == SEQ_MANUAL || seqMode == SEQ_MANUAL_ALT)
        |-> convChannel == controlWord[ADDR_MSB:ADDR_LSB]) else $error("manual channel differs from address");
    chk_consec_bound: assert property (
        convStart && seqMode == SEQ_CONSEC
        |-> convChannel <= controlWord[ADDR_MSB:ADDR_LSB]) else $error("consecutive channel past final");
endmodule

// file: sim/test_adc_channel_sequencer_ranges.sv
// Bench: AHB-Lite master drives the host end, which frames writes to the device end.
// Assumes acs_pkg, acs_link_if and both ends are compiled before it.
module test_adc_channel_sequencer_ranges
    import acs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic [31:0] rd;
    logic convStart;
    logic [2:0] convChannel;
    logic [2:0] ch;
    logic [1:0] convRange;
    logic [1:0] seqMode;
    logic [12:0] controlWord;
    logic [1:0] rng [8];
    logic [2:0] order [5] = '{3'h4, 3'h6, 3'h1, 3'h4, 3'h6};
    int fails = 0;
    int check_count = 0;

    acs_link_if link();

    // Slave ready feeds back as the bus ready; ce is held running
    acs_host acs_host_i (.clk(clk), .resetn(resetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .link(link));
    acs_device acs_device_i (.clk(clk), .resetn(resetn), .ce(1'b1), .link(link), .convStart(convStart),
        .convChannel(convChannel), .convRange(convRange), .seqMode(seqMode), .controlWord(controlWord));
    acs_link_asserts acs_link_asserts_i (.clk(clk), .resetn(resetn), .sclk(link.sclk), .csN(link.csN),
        .din(link.din), .convStart(convStart), .convChannel(convChannel), .seqMode(seqMode),
        .controlWord(controlWord));

    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_field(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded so a dead slave cannot hang the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fails++;
            $display("wrong value hready expected 1 seen %b", hreadyout);
            finish_test();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            bus(1'b0, HOST_REG_STATUS, 32'h0);
            n++;
        end while (rd[STATUS_BUSY_BIT] !== 1'b0 && n < 200);
        if (rd[STATUS_BUSY_BIT] !== 1'b0) begin
            fails++;
            $display("wrong value busy expected 0 seen %b", rd[STATUS_BUSY_BIT]);
            finish_test();
        end
    endtask

    // Device registers land a few clocks after the last serial clock rise
    task automatic send(input logic [15:0] f);
        wait_idle();
        bus(1'b1, HOST_REG_FRAME, {16'h0, f});
        wait_idle();
        repeat (8) @(posedge clk);
    endtask

    function automatic logic [15:0] ctl(input logic [2:0] a, input logic [1:0] s);
        return {1'b1, SEL_CONTROL, a, 6'h0, s, 2'h0};
    endfunction

    task automatic expect_out(input logic [2:0] c);
        cmp_field("channel", {5'h0, c}, {5'h0, convChannel});
        cmp_field("range", {6'h0, rng[c]}, {6'h0, convRange});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 8; i++) begin
            rng[i] = RANGE_RESET;
        end
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        bus(1'b0, HOST_REG_DIVIDER, 32'h0);
        cmp_word("divider", {24'h0, DIVIDER_RESET}, rd);
        bus(1'b0, 8'h40, 32'h0);
        cmp_word("unmapped", 32'h0, rd);
        bus(1'b1, HOST_REG_DIVIDER, 32'h5);
        bus(1'b0, HOST_REG_DIVIDER, 32'h0);
        cmp_word("divider", 32'h5, rd);
        cmp_word("response", 32'h0, {31'h0, hresp});
        expect_out(3'h0);
        $display("test reset done");
        for (int a = 0; a < 8; a++) begin
            send(ctl(3'(a), a[0] ? SEQ_MANUAL_ALT : SEQ_MANUAL));
            expect_out(3'(a));
        end
        $display("test manual done");
        send({1'b1, SEL_RANGE_LOW, 8'h1b, 5'h0});
        send({1'b1, SEL_RANGE_HIGH, 8'he4, 5'h0});
        rng = '{RANGE_PM10V, RANGE_PM5V, RANGE_PM2V5, RANGE_UNI10V,
            RANGE_UNI10V, RANGE_PM2V5, RANGE_PM5V, RANGE_PM10V};
        for (int a = 0; a < 8; a++) begin
            send(ctl(3'(a), SEQ_MANUAL));
            expect_out(3'(a));
        end
        $display("test ranges done");
        send({1'b0, SEL_RANGE_LOW, 8'hff, 5'h0});
        send({1'b0, SEL_CONTROL, 13'h0c0c});
        expect_out(3'h7);
        send(ctl(3'h2, SEQ_MANUAL));
        expect_out(3'h2);
        $display("test write flag done");
        send({1'b1, SEL_CHAN_LIST, 8'h4a, 5'h0});
        send(ctl(3'h0, SEQ_LIST));
        cmp_field("mode", {6'h0, SEQ_LIST}, {6'h0, seqMode});
        expect_out(3'h1);
        for (int k = 0; k < 5; k++) begin
            send(16'h0);
            expect_out(order[k]);
        end
        $display("test list done");
        send(ctl(3'h3, SEQ_CONSEC));
        ch = 3'h0;
        expect_out(ch);
        for (int k = 0; k < 5; k++) begin
            send(16'h0);
            ch = (ch == 3'h3) ? 3'h0 : ch + 3'h1;
            expect_out(ch);
        end
        $display("test consecutive done");
        finish_test();
    end
endmodule
